// [common/rtcev_pkg.sv]
`default_nettype none
package rtcev_pkg;
	// Register addresses
	localparam logic [7:0] ADDR_WD = 8'h09;
	localparam logic [7:0] ADDR_FLAGS = 8'h0F;
	localparam logic [7:0] ADDR_TV = 8'h10;
	localparam logic [7:0] ADDR_TC = 8'h11;
	localparam logic [7:0] ADDR_AL2CTL = 8'h13;
	localparam logic [7:0] ADDR_AL2_FIRST = 8'h14;
	localparam logic [7:0] ADDR_AL2_LAST = 8'h18;
	localparam int AL2_BYTES = 5;
	// Watchdog fields
	localparam int WD_MULT_HI = 6;
	localparam int WD_MULT_LO = 2;
	localparam int WD_RES_HI = 1;
	localparam int WD_RES_LO = 0;
	localparam logic [7:0] WD_WMASK = 8'h7F;
	localparam logic [7:0] WD_RST = 8'h00;
	localparam logic [1:0] WD_RES_16TH = 2'h0;
	localparam logic [1:0] WD_RES_QUARTER = 2'h1;
	localparam logic [1:0] WD_RES_ONE = 2'h2;
	// Timer control fields
	localparam int TC_RUN = 7;
	localparam int TC_PULSE = 6;
	localparam int TC_TIE = 5;
	localparam int TC_SRC_HI = 1;
	localparam int TC_SRC_LO = 0;
	localparam logic [7:0] TC_WMASK = 8'hE3;
	localparam logic [7:0] TC_RST = 8'h00;
	localparam logic [7:0] TV_RST = 8'h00;
	localparam logic [1:0] SRC_4096 = 2'h0;
	localparam logic [1:0] SRC_64 = 2'h1;
	localparam logic [1:0] SRC_1 = 2'h2;
	// Flag bit positions
	localparam int FLAG_WDF = 7;
	localparam int FLAG_AF1 = 6;
	localparam int FLAG_AF2 = 5;
	localparam int FLAG_BL = 4;
	localparam int FLAG_TF = 3;
	localparam int FLAG_OF = 2;
	// Second alarm fields
	localparam int SECOND_ALARM_ENABLE_BIT = 1;
	localparam int SECOND_ALARM_IRQ_ENABLE_BIT = 7;
	localparam int RPT_HI_BIT = 7;
	localparam int RPT_LO_BIT = 6;
	localparam logic [7:0] CTL13_RST = 8'h00;
	localparam logic [7:0] AL2_RST = 8'h00;
	localparam logic [4:0] RPT_SEC = 5'h1F;
	localparam logic [4:0] RPT_MIN = 5'h1E;
	localparam logic [4:0] RPT_HOUR = 5'h1C;
	localparam logic [4:0] RPT_DAY = 5'h18;
	localparam logic [4:0] RPT_MONTH = 5'h10;
	localparam logic [4:0] RPT_YEAR = 5'h00;
	// Timebase: oscillator edges per second and divider chain
	localparam int OSC_HZ = 32768;
	localparam int DIV_OSC_8K = OSC_HZ / 8192;
	localparam int DIV_8K_4K = 2;
	localparam int DIV_4K_64 = 64;
	localparam int DIV_64_16 = 4;
	localparam int DIV_16_4 = 4;
	localparam int DIV_4_1 = 4;
	localparam int DIV_1_Q = 4;
	localparam int DIV_1_MIN = 60;
	// Pulse widths in 1/8192 s ticks
	localparam logic [7:0] PW_8K_N1 = 8'h01;
	localparam logic [7:0] PW_4K = 8'h02;
	localparam logic [7:0] PW_64_N1 = 8'h40;
	localparam logic [7:0] PW_SLOW = 8'h80;
endpackage
`default_nettype wire

// [hw/rtcev_sync_edge.sv]
`default_nettype none
module rtcev_sync_edge (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Asynchronous input
	input wire logic din,
	// Synchronised level and rising edge
	output logic level,
	output logic rise
);
	logic meta;
	logic sync;
	logic prev;

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			meta <= 1'b0;
			sync <= 1'b0;
			prev <= 1'b0;
		end
		else
		begin
			meta <= din;
			sync <= meta;
			prev <= sync;
		end
	end

	assign level = sync;
	assign rise = sync & ~prev;
endmodule
`default_nettype wire

// [hw/rtcev_mod_div.sv]
`default_nettype none
module rtcev_mod_div #(
	parameter int N = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Input rate and divided rate
	input wire logic en,
	output logic tick
);
	localparam int W = (N > 1) ? $clog2(N) : 1;
	localparam logic [W-1:0] TOP = W'(N - 1);
	logic [W-1:0] cnt;

	assign tick = en && (cnt == TOP);

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			cnt <= '0;
		else if (en)
			cnt <= tick ? '0 : cnt + 1'b1;
	end
endmodule
`default_nettype wire

// [hw/rtcev_top.sv]
`default_nettype none
module rtcev_top (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Register port from the serial engine
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Timebase and supply
	input wire logic osc_clk,
	input wire logic power_down,
	// Time of day
	input wire logic time_update,
	input wire logic [6:0] time_sec,
	input wire logic [6:0] time_min,
	input wire logic [5:0] time_hour,
	input wire logic [5:0] time_date,
	input wire logic [4:0] time_month,
	// Neighbouring control and status
	input wire logic first_alarm_match,
	input wire logic first_alarm_irq_enable,
	input wire logic osc_fail_flag,
	input wire logic osc_fail_irq_enable,
	input wire logic out_level,
	input wire logic freq_test_enable,
	input wire logic square_out_enable,
	input wire logic freq_test_wave,
	input wire logic battery_low_flag,
	// Interrupt pins
	output logic shared_irq_out_b,
	output logic shared_irq_oe,
	output logic second_alarm_irq_out_b
);
	logic osc_rise;
	logic pd_level;
	logic t8k, t4k, t64, t16, t4, t1, tq, tmin;

	rtcev_sync_edge u_osc (.clk(mclk), .rst_b(rst_b), .din(osc_clk),
		.level(), .rise(osc_rise));
	rtcev_sync_edge u_pd (.clk(mclk), .rst_b(rst_b), .din(power_down),
		.level(pd_level), .rise());

	rtcev_mod_div #(.N(rtcev_pkg::DIV_OSC_8K)) u_d8k (.clk(mclk),
		.rst_b(rst_b), .en(osc_rise), .tick(t8k));
	rtcev_mod_div #(.N(rtcev_pkg::DIV_8K_4K)) u_d4k (.clk(mclk),
		.rst_b(rst_b), .en(t8k), .tick(t4k));
	rtcev_mod_div #(.N(rtcev_pkg::DIV_4K_64)) u_d64 (.clk(mclk),
		.rst_b(rst_b), .en(t4k), .tick(t64));
	rtcev_mod_div #(.N(rtcev_pkg::DIV_64_16)) u_d16 (.clk(mclk),
		.rst_b(rst_b), .en(t64), .tick(t16));
	rtcev_mod_div #(.N(rtcev_pkg::DIV_16_4)) u_d4 (.clk(mclk),
		.rst_b(rst_b), .en(t16), .tick(t4));
	rtcev_mod_div #(.N(rtcev_pkg::DIV_4_1)) u_d1 (.clk(mclk),
		.rst_b(rst_b), .en(t4), .tick(t1));
	rtcev_mod_div #(.N(rtcev_pkg::DIV_1_Q)) u_dq (.clk(mclk),
		.rst_b(rst_b), .en(t1), .tick(tq));
	rtcev_mod_div #(.N(rtcev_pkg::DIV_1_MIN)) u_dmin (.clk(mclk),
		.rst_b(rst_b), .en(t1), .tick(tmin));

	// Register decode
	logic wr_wd, wr_tv, wr_tc, wr_ctl13, rd_flags, al2_sel;
	logic [2:0] al2_idx;
	assign wr_wd = reg_wr && (reg_addr == rtcev_pkg::ADDR_WD);
	assign wr_tv = reg_wr && (reg_addr == rtcev_pkg::ADDR_TV);
	assign wr_tc = reg_wr && (reg_addr == rtcev_pkg::ADDR_TC);
	assign wr_ctl13 = reg_wr && (reg_addr == rtcev_pkg::ADDR_AL2CTL);
	assign rd_flags = reg_rd && (reg_addr == rtcev_pkg::ADDR_FLAGS);
	assign al2_sel = (reg_addr >= rtcev_pkg::ADDR_AL2_FIRST) &&
		(reg_addr <= rtcev_pkg::ADDR_AL2_LAST);
	assign al2_idx = 3'(reg_addr - rtcev_pkg::ADDR_AL2_FIRST);

	// Second alarm storage
	logic [7:0] ctl13;
	logic [7:0] al2 [rtcev_pkg::AL2_BYTES];
	logic al2_en, second_alarm_irq_enable, al2_hit, al2_flag, af1_flag;
	logic [4:0] rpt, rpt_eff;
	logic rpt_valid;

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			ctl13 <= rtcev_pkg::CTL13_RST;
		else if (wr_ctl13)
			ctl13 <= reg_wdata;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			for (int i = 0; i < rtcev_pkg::AL2_BYTES; i++)
				al2[i] <= rtcev_pkg::AL2_RST;
		end
		else if (reg_wr && al2_sel)
			al2[al2_idx] <= reg_wdata;
	end

	assign al2_en = ctl13[rtcev_pkg::SECOND_ALARM_ENABLE_BIT];
	assign second_alarm_irq_enable = al2[0][rtcev_pkg::SECOND_ALARM_IRQ_ENABLE_BIT];
	assign rpt = {al2[1][rtcev_pkg::RPT_HI_BIT], al2[1][rtcev_pkg::RPT_LO_BIT],
		al2[2][rtcev_pkg::RPT_HI_BIT], al2[3][rtcev_pkg::RPT_HI_BIT],
		al2[4][rtcev_pkg::RPT_HI_BIT]};
	assign rpt_valid = (rpt == rtcev_pkg::RPT_SEC) ||
		(rpt == rtcev_pkg::RPT_MIN) || (rpt == rtcev_pkg::RPT_HOUR) ||
		(rpt == rtcev_pkg::RPT_DAY) || (rpt == rtcev_pkg::RPT_MONTH) ||
		(rpt == rtcev_pkg::RPT_YEAR);
	// Unlisted codes fall back to once per second
	assign rpt_eff = rpt_valid ? rpt : rtcev_pkg::RPT_SEC;
	assign al2_hit = al2_en && time_update &&
		(rpt_eff[0] || (time_sec == al2[4][6:0])) &&
		(rpt_eff[1] || (time_min == al2[3][6:0])) &&
		(rpt_eff[2] || (time_hour == al2[2][5:0])) &&
		(rpt_eff[3] || (time_date == al2[1][5:0])) &&
		(rpt_eff[4] || (time_month == al2[0][4:0]));

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			al2_flag <= 1'b0;
		else if (al2_hit)
			al2_flag <= 1'b1;
		else if (rd_flags)
			al2_flag <= 1'b0;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			af1_flag <= 1'b0;
		else if (first_alarm_match)
			af1_flag <= 1'b1;
		else if (rd_flags)
			af1_flag <= 1'b0;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			second_alarm_irq_out_b <= 1'b1;
		else
			second_alarm_irq_out_b <= !(al2_flag && second_alarm_irq_enable && al2_en);
	end

	// Watchdog
	logic [7:0] wd_reg;
	logic [4:0] wd_mult, wd_cnt;
	logic [1:0] wd_res;
	logic wd_prog, wd_tick, wd_expire, wd_irq, wd_flag;
	assign wd_mult = wd_reg[rtcev_pkg::WD_MULT_HI:rtcev_pkg::WD_MULT_LO];
	assign wd_res = wd_reg[rtcev_pkg::WD_RES_HI:rtcev_pkg::WD_RES_LO];
	assign wd_prog = (wd_mult != 5'h00);
	always_comb
	begin
		case (wd_res)
			rtcev_pkg::WD_RES_16TH: wd_tick = t16;
			rtcev_pkg::WD_RES_QUARTER: wd_tick = t4;
			rtcev_pkg::WD_RES_ONE: wd_tick = t1;
			default: wd_tick = tq;
		endcase
	end
	assign wd_expire = wd_prog && !wd_irq && wd_tick &&
		((wd_cnt + 5'h01) == wd_mult);

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			wd_reg <= rtcev_pkg::WD_RST;
		else if (wr_wd)
			wd_reg <= reg_wdata & rtcev_pkg::WD_WMASK;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			wd_cnt <= 5'h00;
		else if (wr_wd)
			wd_cnt <= 5'h00;
		else if (wd_prog && !wd_irq && wd_tick)
			wd_cnt <= wd_cnt + 5'h01;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			wd_irq <= 1'b0;
		else if (wd_expire)
			wd_irq <= 1'b1;
		else if (wr_wd && (reg_wdata == rtcev_pkg::WD_RST))
			wd_irq <= 1'b0;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			wd_flag <= 1'b0;
		else if (wd_expire)
			wd_flag <= 1'b1;
		else if (rd_flags)
			wd_flag <= 1'b0;
	end

	// Countdown timer
	logic [7:0] tc_reg, tv_reload, tv_count, pw_cnt, pw_sel;
	logic tmr_run, tmr_pmode, tmr_tie, tmr_src, tmr_live, tmr_end;
	logic tmr_flag, pulse_en, tmr_pulse;
	logic [1:0] src_sel;
	assign tmr_run = tc_reg[rtcev_pkg::TC_RUN];
	assign tmr_pmode = tc_reg[rtcev_pkg::TC_PULSE];
	assign tmr_tie = tc_reg[rtcev_pkg::TC_TIE];
	assign src_sel = tc_reg[rtcev_pkg::TC_SRC_HI:rtcev_pkg::TC_SRC_LO];
	always_comb
	begin
		case (src_sel)
			rtcev_pkg::SRC_4096: tmr_src = t4k;
			rtcev_pkg::SRC_64: tmr_src = t64;
			rtcev_pkg::SRC_1: tmr_src = t1;
			default: tmr_src = tmin;
		endcase
	end
	assign tmr_live = tmr_run && (tv_reload != 8'h00);
	assign tmr_end = tmr_live && tmr_src && (tv_count <= 8'h01);

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			tc_reg <= rtcev_pkg::TC_RST;
		else if (pd_level)
			tc_reg[rtcev_pkg::TC_RUN] <= 1'b0;
		else if (wr_tc)
			tc_reg <= reg_wdata & rtcev_pkg::TC_WMASK;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			tv_reload <= rtcev_pkg::TV_RST;
		else if (wr_tv)
			tv_reload <= reg_wdata;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			tv_count <= rtcev_pkg::TV_RST;
		else if (wr_tv)
			tv_count <= reg_wdata;
		else if (tmr_end)
			tv_count <= tv_reload;
		else if (tmr_live && tmr_src)
			tv_count <= tv_count - 8'h01;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			tmr_flag <= 1'b0;
		else if (tmr_end)
			tmr_flag <= 1'b1;
		else if (rd_flags)
			tmr_flag <= 1'b0;
	end

	always_comb
	begin
		case (src_sel)
			rtcev_pkg::SRC_4096:
				pw_sel = (tv_reload == 8'h01) ? rtcev_pkg::PW_8K_N1 :
					rtcev_pkg::PW_4K;
			rtcev_pkg::SRC_64:
				pw_sel = (tv_reload == 8'h01) ? rtcev_pkg::PW_64_N1 :
					rtcev_pkg::PW_SLOW;
			default: pw_sel = rtcev_pkg::PW_SLOW;
		endcase
	end
	assign pulse_en = tmr_run && tmr_tie && tmr_pmode;
	assign tmr_pulse = (pw_cnt != 8'h00);

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			pw_cnt <= 8'h00;
		else if (!pulse_en)
			pw_cnt <= 8'h00;
		else if (tmr_end)
			pw_cnt <= pw_sel;
		else if (t8k && tmr_pulse)
			pw_cnt <= pw_cnt - 8'h01;
	end

	// Shared interrupt pin, open drain
	logic steady_irq, tmr_irq, ft_sel, next_low;
	assign steady_irq = (af1_flag && first_alarm_irq_enable) || wd_irq ||
		(osc_fail_flag && osc_fail_irq_enable) || !out_level;
	assign tmr_irq = tmr_pmode ? tmr_pulse : (tmr_flag && tmr_tie);
	assign ft_sel = freq_test_enable && !square_out_enable && out_level &&
		!wd_prog;
	assign next_low = ft_sel ? !freq_test_wave : (steady_irq || tmr_irq);

	// No supply gating: interrupt stays live on backup
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			shared_irq_out_b <= 1'b1;
			shared_irq_oe <= 1'b0;
		end
		else
		begin
			shared_irq_out_b <= !next_low;
			shared_irq_oe <= next_low;
		end
	end

	// Register read port
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			reg_rdata <= 8'h00;
		else if (reg_rd)
		begin
			reg_rdata <= 8'h00;
			case (reg_addr)
				rtcev_pkg::ADDR_WD: reg_rdata <= wd_reg;
				rtcev_pkg::ADDR_FLAGS:
				begin
					reg_rdata[rtcev_pkg::FLAG_WDF] <= wd_flag;
					reg_rdata[rtcev_pkg::FLAG_AF1] <= af1_flag;
					reg_rdata[rtcev_pkg::FLAG_AF2] <= al2_flag;
					reg_rdata[rtcev_pkg::FLAG_BL] <= battery_low_flag;
					reg_rdata[rtcev_pkg::FLAG_TF] <= tmr_flag;
					reg_rdata[rtcev_pkg::FLAG_OF] <= osc_fail_flag;
				end
				rtcev_pkg::ADDR_TV: reg_rdata <= tv_count;
				rtcev_pkg::ADDR_TC: reg_rdata <= tc_reg;
				rtcev_pkg::ADDR_AL2CTL: reg_rdata <= ctl13;
				default:
					if (al2_sel)
						reg_rdata <= al2[al2_idx];
			endcase
		end
	end

	// Checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);

	sequence s_flags_read;
		rd_flags && !tmr_end && !wd_expire && !al2_hit;
	endsequence
	sequence s_wd_zero;
		wr_wd && (reg_wdata == rtcev_pkg::WD_RST) && !wd_expire;
	endsequence

	property p_al2_match;
		al2_hit |=> al2_flag ##1
			(second_alarm_irq_out_b == !($past(second_alarm_irq_enable) && $past(al2_en)));
	endproperty
	a_al2_match: assert property (p_al2_match)
		else $error("second alarm flag or pin missed");

	property p_flags_clear;
		s_flags_read |=> !wd_flag && !tmr_flag && !al2_flag;
	endproperty
	a_flags_clear: assert property (p_flags_clear)
		else $error("flags read did not clear flags");

	property p_wd_restart;
		wr_wd |=> (wd_cnt == 5'h00);
	endproperty
	a_wd_restart: assert property (p_wd_restart)
		else $error("watchdog write did not restart");

	property p_wd_release;
		s_wd_zero |=> !wd_irq && !wd_prog;
	endproperty
	a_wd_release: assert property (p_wd_release)
		else $error("watchdog zero write did not release");

	property p_wd_expire;
		wd_expire |=> wd_irq && wd_flag ##1 !shared_irq_out_b;
	endproperty
	a_wd_expire: assert property (p_wd_expire)
		else $error("watchdog expiry not signalled");

	property p_wd_power_up;
		$rose(rst_b) |-> (wd_reg == rtcev_pkg::WD_RST) && !wd_irq;
	endproperty
	a_wd_power_up: assert property (p_wd_power_up)
		else $error("watchdog not clear at power-up");

	property p_tmr_reload;
		tmr_end && !wr_tv |=> tmr_flag && (tv_count == tv_reload);
	endproperty
	a_tmr_reload: assert property (p_tmr_reload)
		else $error("timer did not reload with flag");

	property p_tmr_zero;
		(tv_reload == 8'h00) && !wr_tv |=> $stable(tv_count) && !tmr_flag ||
			$past(tmr_flag);
	endproperty
	a_tmr_zero: assert property (p_tmr_zero)
		else $error("zero count timer moved");

	property p_tv_write_keeps_flag;
		tmr_flag && wr_tv && !rd_flags |=> tmr_flag;
	endproperty
	a_tv_write_keeps_flag: assert property (p_tv_write_keeps_flag)
		else $error("value write cleared timer flag");

	property p_pulse_start;
		tmr_end && pulse_en |=> tmr_flag && (pw_cnt == $past(pw_sel));
	endproperty
	a_pulse_start: assert property (p_pulse_start)
		else $error("pulse width or start wrong");

	property p_pulse_persist;
		pulse_en && (pw_cnt > 8'h01) && $stable(tc_reg) |=> tmr_pulse;
	endproperty
	a_pulse_persist: assert property (p_pulse_persist)
		else $error("pulse stopped early");

	property p_steady_low;
		steady_irq && !ft_sel |=> !shared_irq_out_b && shared_irq_oe;
	endproperty
	a_steady_low: assert property (p_steady_low)
		else $error("steady interrupt not held low");

	property p_level_follow;
		!tmr_pmode && tmr_tie && tmr_flag && !ft_sel |=> !shared_irq_out_b;
	endproperty
	a_level_follow: assert property (p_level_follow)
		else $error("level mode interrupt not asserted");

	property p_power_down;
		pd_level |=> !tmr_run;
	endproperty
	a_power_down: assert property (p_power_down)
		else $error("power-down left timer running");
endmodule
`default_nettype wire

// [testbench/rtcev_host_model.sv]
`default_nettype none
module rtcev_host_model (
	// Clock and read data
	input wire logic mclk,
	input wire logic [7:0] reg_rdata,
	// Register strobes
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// Idle lines show the inverse of the last value
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge mclk);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask

	// Data sampled on the second falling edge after the answer lands
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge mclk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge mclk);
		reg_rd = 1'b0;
		reg_addr = ~a;
		@(negedge mclk);
		d = reg_rdata;
	endtask
endmodule
`default_nettype wire

// [testbench/rtcev_top_tb.sv]
`default_nettype none
module rtcev_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, rst_b, osc_clk, power_down, time_update;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic reg_wr, reg_rd;
	logic [6:0] time_sec, time_min;
	logic [5:0] time_hour, time_date;
	logic [4:0] time_month;
	logic first_alarm_match, first_alarm_irq_enable, osc_fail_flag;
	logic osc_fail_irq_enable, out_level, freq_test_enable;
	logic square_out_enable, freq_test_wave, battery_low_flag;
	logic shared_irq_out_b, shared_irq_oe, second_alarm_irq_out_b;
	int failures, checks, w, k;
	logic [7:0] v, v1;
	logic [1:0] p_src [3] = '{2'h0, 2'h0, 2'h1};
	logic [7:0] p_n [3] = '{8'h02, 8'h01, 8'h01};
	int p_w [3] = '{160, 80, 5120};

	rtcev_top i_dut (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .osc_clk(osc_clk), .power_down(power_down),
		.time_update(time_update), .time_sec(time_sec),
		.time_min(time_min), .time_hour(time_hour), .time_date(time_date),
		.time_month(time_month), .first_alarm_match(first_alarm_match),
		.first_alarm_irq_enable(first_alarm_irq_enable),
		.osc_fail_flag(osc_fail_flag),
		.osc_fail_irq_enable(osc_fail_irq_enable), .out_level(out_level),
		.freq_test_enable(freq_test_enable),
		.square_out_enable(square_out_enable),
		.freq_test_wave(freq_test_wave),
		.battery_low_flag(battery_low_flag),
		.shared_irq_out_b(shared_irq_out_b), .shared_irq_oe(shared_irq_oe),
		.second_alarm_irq_out_b(second_alarm_irq_out_b));

	rtcev_host_model i_host (.mclk(mclk), .reg_rdata(reg_rdata),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd));

	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	initial
	begin
		osc_clk = 1'b0;
		#37;
		forever #80 osc_clk = ~osc_clk;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
			failures++;
		end
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		i_host.rd(a, d);
		check(d, exp);
	endtask

	task automatic pin(input logic exp, input int n);
		int i;
		i = 0;
		while (shared_irq_oe !== exp && i < n)
		begin
			@(negedge mclk);
			i++;
		end
		check({7'h00, shared_irq_oe}, {7'h00, exp});
	endtask

	task automatic tick(input logic [6:0] s);
		@(negedge mclk);
		time_sec = s;
		time_update = 1'b1;
		@(negedge mclk);
		time_update = 1'b0;
		repeat (3) @(negedge mclk);
	endtask

	task automatic summarize();
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial
	begin
		#720000;
		failures++;
		summarize();
	end

	initial
	begin
		{power_down, time_update, first_alarm_match} = 3'h0;
		{first_alarm_irq_enable, osc_fail_flag, osc_fail_irq_enable} = 3'h0;
		{freq_test_enable, square_out_enable, freq_test_wave} = 3'h0;
		battery_low_flag = 1'b0;
		out_level = 1'b1;
		time_sec = 7'h00;
		time_min = 7'h00;
		time_hour = 6'h00;
		time_date = 6'h01;
		time_month = 5'h01;
		failures = 0;
		checks = 0;
		rst_b = 1'b0;
		repeat (8) @(negedge mclk);
		rst_b = 1'b1;
		rdc(rtcev_pkg::ADDR_WD, 8'h00);
		rdc(rtcev_pkg::ADDR_FLAGS, 8'h00);
		rdc(rtcev_pkg::ADDR_TC, 8'h00);
		rdc(rtcev_pkg::ADDR_AL2CTL, 8'h00);
		rdc(8'h3F, 8'h00);
		for (int i = 0; i < 5; i++)
			i_host.wr(8'h14 + 8'(i), 8'h5A ^ 8'(i));
		for (int i = 0; i < 5; i++)
			rdc(8'h14 + 8'(i), 8'h5A ^ 8'(i));
		i_host.wr(rtcev_pkg::ADDR_WD, 8'hFF);
		rdc(rtcev_pkg::ADDR_WD, 8'h7F);
		i_host.wr(rtcev_pkg::ADDR_WD, 8'h00);
		i_host.wr(rtcev_pkg::ADDR_TV, 8'h00);
		i_host.wr(rtcev_pkg::ADDR_TC, 8'hFF);
		rdc(rtcev_pkg::ADDR_TC, 8'hE3);
		repeat (400) @(negedge mclk);
		rdc(rtcev_pkg::ADDR_FLAGS, 8'h00);
		// Second alarm, per second then per minute
		i_host.wr(8'h14, 8'h80);
		i_host.wr(8'h15, 8'hC0);
		i_host.wr(8'h16, 8'h80);
		i_host.wr(8'h17, 8'h80);
		i_host.wr(8'h18, 8'h80);
		i_host.wr(rtcev_pkg::ADDR_AL2CTL, 8'h02);
		tick(7'h10);
		check({7'h00, second_alarm_irq_out_b}, 8'h00);
		rdc(rtcev_pkg::ADDR_FLAGS, 8'h20);
		repeat (2) @(negedge mclk);
		check({7'h00, second_alarm_irq_out_b}, 8'h01);
		rdc(rtcev_pkg::ADDR_FLAGS, 8'h00);
		i_host.wr(8'h18, 8'h30);
		tick(7'h29);
		rdc(rtcev_pkg::ADDR_FLAGS, 8'h00);
		tick(7'h30);
		rdc(rtcev_pkg::ADDR_FLAGS, 8'h20);
		// Shared pin sources
		first_alarm_irq_enable = 1'b1;
		@(negedge mclk);
		first_alarm_match = 1'b1;
		@(negedge mclk);
		first_alarm_match = 1'b0;
		pin(1'b1, 4);
		check({7'h00, shared_irq_out_b}, 8'h00);
		rdc(rtcev_pkg::ADDR_FLAGS, 8'h40);
		pin(1'b0, 3);
		{osc_fail_flag, osc_fail_irq_enable, battery_low_flag} = 3'h7;
		pin(1'b1, 6);
		rdc(rtcev_pkg::ADDR_FLAGS, 8'h14);
		{osc_fail_flag, osc_fail_irq_enable, battery_low_flag} = 3'h0;
		pin(1'b0, 6);
		// Frequency test against watchdog
		freq_test_enable = 1'b1;
		pin(1'b1, 4);
		freq_test_wave = 1'b1;
		pin(1'b0, 4);
		freq_test_wave = 1'b0;
		i_host.wr(rtcev_pkg::ADDR_WD, 8'h04);
		repeat (3) @(negedge mclk);
		check({7'h00, shared_irq_oe}, 8'h00);
		freq_test_enable = 1'b0;
		pin(1'b1, 42000);
		rdc(rtcev_pkg::ADDR_FLAGS, 8'h80);
		rdc(rtcev_pkg::ADDR_FLAGS, 8'h00);
		check({7'h00, shared_irq_oe}, 8'h01);
		i_host.wr(rtcev_pkg::ADDR_WD, 8'h00);
		pin(1'b0, 3);
		// Level mode timer
		i_host.wr(rtcev_pkg::ADDR_TV, 8'h02);
		i_host.wr(rtcev_pkg::ADDR_TC, 8'hA0);
		pin(1'b1, 400);
		i_host.wr(rtcev_pkg::ADDR_TV, 8'h02);
		repeat (2) @(negedge mclk);
		check({7'h00, shared_irq_oe}, 8'h01);
		rdc(rtcev_pkg::ADDR_FLAGS, 8'h08);
		pin(1'b0, 3);
		i_host.rd(rtcev_pkg::ADDR_TV, v);
		check({7'h00, v == 8'h01 || v == 8'h02}, 8'h01);
		pin(1'b1, 400);
		i_host.wr(rtcev_pkg::ADDR_TC, 8'h80);
		pin(1'b0, 3);
		// Pulse widths for source and count
		for (int i = 0; i < 3; i++)
		begin
			i_host.wr(rtcev_pkg::ADDR_TV, p_n[i]);
			i_host.wr(rtcev_pkg::ADDR_TC, 8'hE0 | {6'h00, p_src[i]});
			rdc(rtcev_pkg::ADDR_FLAGS, 8'h08);
			pin(1'b1, 11000);
			w = 0;
			while (shared_irq_oe === 1'b1 && w < 6000)
			begin
				@(negedge mclk);
				w++;
			end
			check({7'h00, w >= p_w[i] - 2 && w <= p_w[i] + 2}, 8'h01);
		end
		pin(1'b1, 11000);
		// Steady source must hold the pin through a pulse gap
		pin(1'b0, 6000);
		out_level = 1'b0;
		k = 0;
		repeat (400)
		begin
			@(negedge mclk);
			k += int'(shared_irq_oe === 1'b1);
		end
		check({7'h00, k == 400}, 8'h01);
		out_level = 1'b1;
		i_host.wr(rtcev_pkg::ADDR_TC, 8'h00);
		pin(1'b0, 6000);
		// Power-down stops the count, resume keeps it
		i_host.wr(rtcev_pkg::ADDR_TV, 8'hC8);
		i_host.wr(rtcev_pkg::ADDR_TC, 8'h80);
		repeat (800) @(negedge mclk);
		power_down = 1'b1;
		repeat (8) @(negedge mclk);
		rdc(rtcev_pkg::ADDR_TC, 8'h00);
		i_host.rd(rtcev_pkg::ADDR_TV, v1);
		check({7'h00, v1 >= 8'hC1 && v1 <= 8'hC5}, 8'h01);
		out_level = 1'b0;
		pin(1'b1, 4);
		repeat (400) @(negedge mclk);
		out_level = 1'b1;
		pin(1'b0, 4);
		i_host.rd(rtcev_pkg::ADDR_TV, v);
		check({7'h00, v == v1}, 8'h01);
		power_down = 1'b0;
		// Let the synchronised power-down level fall before re-enabling
		repeat (4) @(negedge mclk);
		i_host.wr(rtcev_pkg::ADDR_TC, 8'h80);
		repeat (330) @(negedge mclk);
		i_host.rd(rtcev_pkg::ADDR_TV, v);
		check({7'h00, v < v1 && v + 8'h04 > v1}, 8'h01);
		summarize();
	end
endmodule
`default_nettype wire
